// ==== design/npt_decode.sv ====
// Decode and execute slice for nibble pointer, stack and timer transfers
//
// Contract
// RL1 - Opcode 0x56 is a one-cycle no-operation changing nothing.
// RL2 - Load pointer nibble into accumulator; zero updated, carry kept, status one.
// RL3 - Load stack pointer into accumulator; zero updated, carry kept, status one.
// RL4 - Load timer A nibble into accumulator; zero updated, status one.
// RL5 - Load timer B nibble into accumulator; zero updated, status one.
// RL6 - Store accumulator to pointer nibble; carry, zero kept, status one.
// RL7 - Store accumulator to stack pointer; carry, zero kept, status one.
// RL8 - Store accumulator to timer A nibble; status one.
// RL9 - Store accumulator to timer B nibble; status one.
// RL10 - Data pointer is three addressable nibbles forming twelve bits.
// RL11 - Timer registers are three nibbles chosen by second byte bits 1:0.
// RL12 - Table reads at the pointer return low and high nibble of byte.
// RL13 - Operand fields: imm 4, RAM 8, zero-page 4, port 5, latch 6.
// RL14 - Both bytes fetched before any register write commits.
`timescale 1ns/1ps
module npt_decode (
  input wire logic clk_in, // Core clock, 125 MHz
  input wire logic nrst_in, // Synchronous reset, active low
  input wire logic byte_valid_in, // Fetch sequencer offers a byte
  input wire logic [7:0] byte_in, // Program byte
  input wire logic [7:0] rom_data_in, // Program memory byte at pointer
  input wire logic carry_in, // Carry flag from core
  output logic byte_take_out, // Byte consumed at the last edge
  output logic [3:0] acc_out, // Accumulator
  output logic zero_flag_out, // Zero flag
  output logic status_flag_out, // Status flag
  output logic carry_flag_out, // Carry flag, passed unchanged
  output logic [11:0] data_pointer_out, // Data pointer, also table address
  output logic [3:0] stack_pointer_out, // Stack pointer
  output logic [11:0] timer_a_count_out, // Timer/counter A value
  output logic [11:0] timer_b_count_out, // Timer/counter B value
  output logic [3:0] rom_low_out, // Table byte low nibble
  output logic [3:0] rom_high_out, // Table byte high nibble
  output logic done_out, // Instruction retired pulse
  output logic illegal_out, // Opcode outside this slice pulse
  output logic [3:0] fld_imm_out, // Immediate field of last second byte
  output logic [7:0] fld_ram_out, // Direct RAM address field
  output logic [3:0] fld_zp_out, // Zero-page address field
  output logic [4:0] fld_port_out, // Port address field
  output logic [5:0] fld_latch_out // Interrupt latch operand field
);
  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  npt_pkg::npt_state_e state_r, state_nxt;
  logic [7:0] first_r, first_nxt;
  logic [7:0] second_r, second_nxt;
  logic [3:0] acc_nxt;
  logic zero_nxt, status_nxt, carry_nxt, done_nxt, illegal_nxt, take_nxt;
  logic [3:0] sp_nxt;
  logic wr_ptr, wr_ta, wr_tb;
  logic [1:0] sel;
  logic [3:0] rd_nib;
  logic [11:0] dp_q, ta_q, tb_q;
  logic is_load, is_store, legal2;

  // Second byte field decode
  assign sel = second_r[1:0]; // [RL11]
  assign is_load = (first_r == npt_pkg::OP_LOAD_PREFIX);
  assign is_store = (first_r == npt_pkg::OP_STORE_PREFIX);
  assign legal2 = (second_r[7:4] == npt_pkg::SUB_HIGH) &&
                  (second_r[3:2] != 2'b00) &&
                  (second_r[3:2] == npt_pkg::GRP_POINTER ||
                   sel != npt_pkg::SEL_STACK);

  // Nibble picked for a load
  always_comb begin
    rd_nib = 4'h0;
    case (second_r[3:2])
      npt_pkg::GRP_POINTER: begin
        case (sel)
          npt_pkg::SEL_LOW: rd_nib = dp_q[3:0]; // [RL2] [RL10]
          npt_pkg::SEL_MID: rd_nib = dp_q[7:4]; // [RL2]
          npt_pkg::SEL_HIGH: rd_nib = dp_q[11:8]; // [RL2]
          default: rd_nib = stack_pointer_out; // [RL3]
        endcase
      end
      npt_pkg::GRP_TIMER_A: rd_nib = ta_q[4*sel +: 4]; // [RL4]
      npt_pkg::GRP_TIMER_B: rd_nib = tb_q[4*sel +: 4]; // [RL5]
      default: rd_nib = 4'h0;
    endcase
  end

  // Next-state logic; writes only commit in EXEC after both bytes
  always_comb begin
    state_nxt = state_r;
    first_nxt = first_r;
    second_nxt = second_r;
    acc_nxt = acc_out;
    zero_nxt = zero_flag_out;
    status_nxt = status_flag_out;
    carry_nxt = carry_in; // Carry is never touched here
    sp_nxt = stack_pointer_out;
    done_nxt = 1'b0;
    illegal_nxt = 1'b0;
    take_nxt = 1'b0;
    wr_ptr = 1'b0;
    wr_ta = 1'b0;
    wr_tb = 1'b0;
    case (state_r)
      npt_pkg::NPT_FETCH1: begin
        if (byte_valid_in) begin
          take_nxt = 1'b1;
          first_nxt = byte_in;
          if (byte_in == npt_pkg::OP_NOP) begin
            done_nxt = 1'b1; // [RL1]
          end else if (byte_in == npt_pkg::OP_LOAD_PREFIX ||
                       byte_in == npt_pkg::OP_STORE_PREFIX) begin
            state_nxt = npt_pkg::NPT_FETCH2;
          end else begin
            illegal_nxt = 1'b1;
          end
        end
      end
      npt_pkg::NPT_FETCH2: begin
        if (byte_valid_in) begin
          take_nxt = 1'b1;
          second_nxt = byte_in; // [RL14]
          state_nxt = npt_pkg::NPT_EXEC;
        end
      end
      npt_pkg::NPT_EXEC: begin
        state_nxt = npt_pkg::NPT_FETCH1;
        done_nxt = legal2;
        illegal_nxt = !legal2;
        if (legal2 && is_load) begin
          acc_nxt = rd_nib; // [RL2] [RL3] [RL4] [RL5]
          zero_nxt = (rd_nib == 4'h0);
          status_nxt = 1'b1;
        end else if (legal2 && is_store) begin
          status_nxt = 1'b1; // [RL6] [RL7] [RL8] [RL9]
          case (second_r[3:2])
            npt_pkg::GRP_POINTER: begin
              if (sel == npt_pkg::SEL_STACK) begin
                sp_nxt = acc_out; // [RL7]
              end else begin
                wr_ptr = 1'b1; // [RL6] [RL14]
              end
            end
            npt_pkg::GRP_TIMER_A: wr_ta = 1'b1; // [RL8]
            npt_pkg::GRP_TIMER_B: wr_tb = 1'b1; // [RL9]
            default: wr_ptr = 1'b0;
          endcase
        end
      end
      default: state_nxt = npt_pkg::NPT_FETCH1;
    endcase
  end

  // Register stage for sequencer and flags
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_r <= npt_pkg::NPT_FETCH1;
      first_r <= 8'h00;
      second_r <= 8'h00;
      acc_out <= npt_pkg::NIB_RST;
      zero_flag_out <= 1'b0;
      status_flag_out <= 1'b0;
      carry_flag_out <= 1'b0;
      stack_pointer_out <= npt_pkg::NIB_RST;
      done_out <= 1'b0;
      illegal_out <= 1'b0;
      byte_take_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      first_r <= first_nxt;
      second_r <= second_nxt;
      acc_out <= acc_nxt;
      zero_flag_out <= zero_nxt;
      status_flag_out <= status_nxt;
      carry_flag_out <= carry_nxt;
      stack_pointer_out <= sp_nxt;
      done_out <= done_nxt;
      illegal_out <= illegal_nxt;
      byte_take_out <= take_nxt;
    end
  end

  // ****************************************************************
  // Twelve-bit targets, one nibble register each
  // ****************************************************************
  npt_nibble_reg u_ptr (.clk_in(clk_in), .nrst_in(nrst_in), .wr_in(wr_ptr),
    .sel_in(sel), .data_in(acc_out), .value_out(dp_q)); // [RL10]
  npt_nibble_reg u_ta (.clk_in(clk_in), .nrst_in(nrst_in), .wr_in(wr_ta),
    .sel_in(sel), .data_in(acc_out), .value_out(ta_q)); // [RL11]
  npt_nibble_reg u_tb (.clk_in(clk_in), .nrst_in(nrst_in), .wr_in(wr_tb),
    .sel_in(sel), .data_in(acc_out), .value_out(tb_q)); // [RL11]

  // Copies to output flops; outputs lag the internal value by one cycle
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      data_pointer_out <= npt_pkg::WIDE_RST;
      timer_a_count_out <= npt_pkg::WIDE_RST;
      timer_b_count_out <= npt_pkg::WIDE_RST;
      rom_low_out <= npt_pkg::NIB_RST;
      rom_high_out <= npt_pkg::NIB_RST;
      fld_imm_out <= 4'h0;
      fld_ram_out <= 8'h00;
      fld_zp_out <= 4'h0;
      fld_port_out <= 5'h00;
      fld_latch_out <= 6'h00;
    end else begin
      data_pointer_out <= dp_q;
      timer_a_count_out <= ta_q;
      timer_b_count_out <= tb_q;
      rom_low_out <= rom_data_in[3:0]; // [RL12]
      rom_high_out <= rom_data_in[7:4]; // [RL12]
      if (byte_valid_in && state_r == npt_pkg::NPT_FETCH2) begin
        fld_imm_out <= byte_in[npt_pkg::IMM_W-1:0]; // [RL13]
        fld_ram_out <= byte_in[npt_pkg::RAM_ADDR_W-1:0]; // [RL13]
        fld_zp_out <= byte_in[npt_pkg::ZP_ADDR_W-1:0]; // [RL13]
        fld_port_out <= byte_in[npt_pkg::PORT_ADDR_W-1:0]; // [RL13]
        fld_latch_out <= byte_in[npt_pkg::IL_W-1:0]; // [RL13]
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence load_seen_s;
    state_r == npt_pkg::NPT_EXEC && legal2 && is_load;
  endsequence

  nop_no_change_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state_r == npt_pkg::NPT_FETCH1 && byte_valid_in &&
    byte_in == npt_pkg::OP_NOP |=> $stable(acc_out) && done_out &&
    $stable(status_flag_out)) // [RL1]
    else $error("nop changed state");
  load_acc_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    load_seen_s |=> acc_out == $past(rd_nib)) // [RL2]
    else $error("load value wrong");
  load_stack_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    load_seen_s ##0 (sel == npt_pkg::SEL_STACK) |=>
    acc_out == stack_pointer_out) // [RL3]
    else $error("stack load wrong");
  load_zero_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    load_seen_s |=> zero_flag_out == (acc_out == 4'h0) && status_flag_out)
    // [RL4]
    else $error("load flags wrong");
  timer_b_load_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    load_seen_s ##0 (second_r[3:2] == npt_pkg::GRP_TIMER_B) |=>
    acc_out == $past(tb_q[4*sel +: 4])) // [RL5]
    else $error("timer b load wrong");
  store_ptr_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    wr_ptr |=> $stable(zero_flag_out) && status_flag_out &&
    dp_q[4*$past(sel) +: 4] == $past(acc_out)) // [RL6]
    else $error("pointer store wrong");
  store_stack_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state_r == npt_pkg::NPT_EXEC && legal2 && is_store &&
    sel == npt_pkg::SEL_STACK |=> stack_pointer_out == $past(acc_out))
    // [RL7]
    else $error("stack store wrong");
  store_ta_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    wr_ta |=> ta_q[4*$past(sel) +: 4] == $past(acc_out)) // [RL8]
    else $error("timer a store wrong");
  store_tb_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    wr_tb |=> tb_q[4*$past(sel) +: 4] == $past(acc_out)) // [RL9]
    else $error("timer b store wrong");
  write_late_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (wr_ptr || wr_ta || wr_tb) |-> state_r == npt_pkg::NPT_EXEC) // [RL14]
    else $error("write before second byte");
endmodule : npt_decode

// ==== design/npt_nibble_reg.sv ====
// One 12-bit register written a nibble at a time
`timescale 1ns/1ps
module npt_nibble_reg (
  input wire logic clk_in, // Core clock
  input wire logic nrst_in, // Synchronous reset, active low
  input wire logic wr_in, // Nibble write strobe
  input wire logic [1:0] sel_in, // Nibble select
  input wire logic [3:0] data_in, // Nibble to write
  output logic [11:0] value_out // Whole register value
);
  logic [11:0] value_nxt;

  // Merge the written nibble into the held value
  always_comb begin
    value_nxt = value_out;
    if (wr_in) begin
      case (sel_in)
        npt_pkg::SEL_LOW: value_nxt[3:0] = data_in;
        npt_pkg::SEL_MID: value_nxt[7:4] = data_in;
        npt_pkg::SEL_HIGH: value_nxt[11:8] = data_in;
        default: value_nxt = value_out;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      value_out <= npt_pkg::WIDE_RST;
    end else begin
      value_out <= value_nxt;
    end
  end
endmodule : npt_nibble_reg

// ==== design/npt_pkg.sv ====
// Package of opcodes, field layouts and reset values for the transfer decoder
package npt_pkg;
  // ****************************************************************
  // Opcode bytes
  // ****************************************************************
  localparam logic [7:0] OP_NOP = 8'h56;
  localparam logic [7:0] OP_LOAD_PREFIX = 8'h6A;
  localparam logic [7:0] OP_STORE_PREFIX = 8'h69;
  localparam logic [3:0] SUB_HIGH = 4'hF;
  // Low two bits of second byte pick the target nibble or the stack pointer
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_MID = 2'h1;
  localparam logic [1:0] SEL_HIGH = 2'h2;
  localparam logic [1:0] SEL_STACK = 2'h3;
  // Bits 3:2 of second byte pick the target group
  localparam logic [1:0] GRP_TIMER_A = 2'h1;
  localparam logic [1:0] GRP_TIMER_B = 2'h2;
  localparam logic [1:0] GRP_POINTER = 2'h3;
  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int NIB_W = 4;
  localparam int WIDE_W = 12;
  localparam int IMM_W = 4;
  localparam int RAM_ADDR_W = 8;
  localparam int ZP_ADDR_W = 4;
  localparam int PORT_ADDR_W = 5;
  localparam int IL_W = 6;
  localparam logic [11:0] WIDE_RST = 12'h000;
  localparam logic [3:0] NIB_RST = 4'h0;

  typedef enum logic [1:0] {
    NPT_FETCH1 = 2'b00,
    NPT_FETCH2 = 2'b01,
    NPT_EXEC = 2'b10
  } npt_state_e;
endpackage : npt_pkg

// ==== sim/npt_decode_tb.sv ====
// Self-checking testbench for the transfer decoder
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    compares++; \
    if ((gt) !== (ex)) begin \
      n_mismatch++; \
      $display("[ERR] %s expected %0h seen %0h", nm, ex, gt); \
    end \
  end
module npt_decode_tb;
  logic clk_in, nrst_in, byte_valid_in, carry_in, byte_take_out;
  logic [7:0] byte_in, rom_data_in, fld_ram_out;
  logic [3:0] acc_out, stack_pointer_out, rom_low_out, rom_high_out;
  logic [3:0] fld_imm_out, fld_zp_out;
  logic zero_flag_out, status_flag_out, carry_flag_out, done_out;
  logic illegal_out;
  logic [11:0] data_pointer_out, timer_a_count_out, timer_b_count_out;
  logic [4:0] fld_port_out;
  logic [5:0] fld_latch_out;
  int compares = 0;
  int n_mismatch = 0;
  int cycles = 0;
  npt_decode npt_decode_inst (.clk_in(clk_in), .nrst_in(nrst_in),
    .byte_valid_in(byte_valid_in), .byte_in(byte_in),
    .rom_data_in(rom_data_in), .carry_in(carry_in),
    .byte_take_out(byte_take_out), .acc_out(acc_out),
    .zero_flag_out(zero_flag_out), .status_flag_out(status_flag_out),
    .carry_flag_out(carry_flag_out), .data_pointer_out(data_pointer_out),
    .stack_pointer_out(stack_pointer_out),
    .timer_a_count_out(timer_a_count_out),
    .timer_b_count_out(timer_b_count_out), .rom_low_out(rom_low_out),
    .rom_high_out(rom_high_out), .done_out(done_out),
    .illegal_out(illegal_out), .fld_imm_out(fld_imm_out),
    .fld_ram_out(fld_ram_out), .fld_zp_out(fld_zp_out),
    .fld_port_out(fld_port_out), .fld_latch_out(fld_latch_out));
  npt_fetch_model partner_inst (.clk_in(clk_in), .take_in(byte_take_out),
    .pointer_in(data_pointer_out), .valid_out(byte_valid_in),
    .byte_out(byte_in), .rom_out(rom_data_in));
  // ************************************************************
  // Clock, timeout and closing report
  // ************************************************************
  always #4 clk_in = ~clk_in;
  // The whole run needs some 110 cycles; a hang is cut well before long
  always @(posedge clk_in) begin
    cycles++;
    if (cycles >= 2000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  // ************************************************************
  // Shared helpers
  // ************************************************************
  // Queue an instruction and count edges until it retires or is refused
  task automatic issue(input logic [7:0] b0, input logic [7:0] b1,
                       input bit two, output int cyc);
    cyc = 0;
    partner_inst.push(b0);
    if (two) begin
      partner_inst.push(b1);
    end
    while (done_out !== 1'b1 && illegal_out !== 1'b1 && cyc < 20) begin
      @(posedge clk_in);
      #2;
      cyc++;
    end
  endtask : issue
  // One legal transfer; all registers start at zero, so zero data is expected
  task automatic xfer(input logic [7:0] p, input logic [7:0] s,
                      input logic ez);
    int cyc;
    issue(p, s, 1'b1, cyc);
    `CHK("cycles", 3, cyc)
    `CHK("done", 1'b1, done_out)
    `CHK("acc", 4'h0, acc_out)
    `CHK("zero", ez, zero_flag_out)
    `CHK("status", 1'b1, status_flag_out)
    `CHK("carry", carry_in, carry_flag_out)
    `CHK("imm", s[3:0], fld_imm_out)
    `CHK("ram", s, fld_ram_out)
    `CHK("zpage", s[3:0], fld_zp_out)
    `CHK("port", s[4:0], fld_port_out)
    `CHK("latch", s[5:0], fld_latch_out)
    @(posedge clk_in);
    #2;
    `CHK("rom low", 4'h5, rom_low_out)
    `CHK("rom high", 4'hA, rom_high_out)
    `CHK("pointer", 12'h000, data_pointer_out)
    `CHK("timer a", 12'h000, timer_a_count_out)
    `CHK("timer b", 12'h000, timer_b_count_out)
    `CHK("stack", 4'h0, stack_pointer_out)
  endtask : xfer
  // ************************************************************
  // Scenarios
  // ************************************************************
  logic [7:0] sel_tab [10] = '{8'hF4, 8'hF5, 8'hF6, 8'hF8, 8'hF9,
                               8'hFA, 8'hFC, 8'hFD, 8'hFE, 8'hFF};
  logic [7:0] bad_tab [4] = '{8'hF3, 8'hF7, 8'hFB, 8'h0C};
  // Refused opcodes must leave the flags at their reset values
  task automatic t_illegal;
    int cyc;
    issue(8'h00, 8'h00, 1'b0, cyc);
    `CHK("illegal first", 1'b1, illegal_out)
    @(posedge clk_in);
    #2;
    for (int i = 0; i < 4; i++) begin
      issue(i[0] ? 8'h69 : 8'h6A, bad_tab[i], 1'b1, cyc);
      `CHK("illegal second", 1'b1, illegal_out)
      `CHK("status kept", 1'b0, status_flag_out)
      `CHK("zero kept", 1'b0, zero_flag_out)
      @(posedge clk_in);
      #2;
    end
    $display("test illegal done");
  endtask : t_illegal
  task automatic t_nop(input logic ez, input logic es);
    int cyc;
    carry_in = ~carry_in;
    issue(8'h56, 8'h00, 1'b0, cyc);
    `CHK("nop cycles", 1, cyc)
    `CHK("nop zero", ez, zero_flag_out)
    `CHK("nop status", es, status_flag_out)
    `CHK("nop carry", carry_in, carry_flag_out)
    @(posedge clk_in);
    #2;
    $display("test nop done");
  endtask : t_nop
  // Stores run first so a kept zero flag is still low
  task automatic t_stores;
    for (int i = 0; i < 10; i++) begin
      carry_in = i[0];
      xfer(8'h69, sel_tab[i], 1'b0);
    end
    $display("test stores done");
  endtask : t_stores
  task automatic t_loads;
    for (int i = 0; i < 10; i++) begin
      carry_in = ~i[0];
      xfer(8'h6A, sel_tab[i], 1'b1);
    end
    $display("test loads done");
  endtask : t_loads
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    clk_in = 1'b0;
    nrst_in = 1'b0;
    carry_in = 1'b0;
    repeat (6) @(posedge clk_in);
    #2;
    nrst_in = 1'b1;
    `CHK("reset acc", 4'h0, acc_out)
    `CHK("reset status", 1'b0, status_flag_out)
    t_illegal();
    t_nop(1'b0, 1'b0);
    t_stores();
    t_loads();
    t_nop(1'b1, 1'b1);
    report_and_stop();
  end
endmodule : npt_decode_tb

// ==== sim/npt_fetch_model.sv ====
// Fetch sequencer and table memory model facing the transfer decoder
`timescale 1ns/1ps
module npt_fetch_model (
  input wire logic clk_in, // Core clock
  input wire logic take_in, // Decoder took a byte at the last edge
  input wire logic [11:0] pointer_in, // Data pointer used as table address
  output logic valid_out, // A byte is offered
  output logic [7:0] byte_out, // Offered program byte
  output logic [7:0] rom_out // Table byte at the pointer
);
  logic [7:0] queue_q[$];
  logic [7:0] last_r = 8'h00;
  // ************************************************************
  // Byte offer
  // ************************************************************
  // When idle the line shows the inverse of the last byte, never a stale copy
  task refresh;
    valid_out = (queue_q.size() > 0);
    byte_out = valid_out ? queue_q[0] : ~last_r;
  endtask : refresh
  task push(input logic [7:0] b);
    queue_q.push_back(b);
    refresh();
  endtask : push
  initial begin
    refresh();
  end
  // Move on just after the edge so the next byte meets the next edge
  always @(posedge clk_in) begin
    #1;
    if (take_in === 1'b1 && queue_q.size() > 0) begin
      last_r = queue_q.pop_front();
    end
    refresh();
  end
  // Table contents are a fixed scramble of the address
  assign rom_out = pointer_in[7:0] ^ pointer_in[11:4] ^ 8'hA5;
endmodule : npt_fetch_model
